// ---- rtl/plc_array_cfg.sv ----
// configuration registers and 32 logic elements of the logic array
// assumes gpio, software and clock source inputs synchronous to clk_sys
//
// Notes on behaviour
// - 32 element configuration words from base address, four bytes apart
// - even feedback picks element 0,2,4,6; first element code 00 takes ring input
// - odd feedback picks element 1,3,5,7 of the same group
// - first lookup input: software bit at 0, even feedback at 1
// - second input: odd feedback at 0, gpio at 1; elements 16-31 always odd
// - lookup bits 4..1 give output for input pairs 11,10,01,00
// - bypass 0 gives flip-flop output, 1 gives lookup result directly
// - clock select register holds 3-bit selector per group at 2:0,6:4,10:8,14:12
// - selector codes: three pins, bus clock, fast osc, timer0, timer2, slow osc
// - line 1 enabled by bit 12, line 0 by bit 4
// - lines 0 and 1 take source element 0..15 from fields 3:0 and 11:8
// - all configuration fields reset to zero
// - enabled line is level, active high, follows selected element output
// - all registered outputs of a group use that group's selected clock
// - ring: element 7 feeds 8, 15 feeds 16, 23 feeds 24, 31 feeds 0
module plc_array_cfg (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire plc_pkg::plc_bus_req_type bus_req,
   output logic [31:0] rdata,
   input wire logic [plc_pkg::GPIO_ELEMS-1:0] gpio_in,
   input wire logic [plc_pkg::NUM_CLK_SRC-1:0] clk_src,
   output logic [plc_pkg::NUM_ELEM-1:0] elem_out,
   output logic [plc_pkg::NUM_LINE-1:0] irq_line,
   output logic irq
);

   typedef struct packed {
      logic [plc_pkg::NUM_ELEM-1:0][15:0] elem;
      logic [15:0] clk_sel;
      logic [15:0] irq_sel;
      logic [plc_pkg::NUM_ELEM-1:0] sw_in;
      logic [plc_pkg::NUM_LINE-1:0] sts;
      logic [plc_pkg::NUM_LINE-1:0] mask;
      logic [plc_pkg::NUM_ELEM-1:0] ff;
      logic [plc_pkg::NUM_CLK_SRC-1:0] src_prev;
      logic [31:0] rdata;
   } plc_state_type;

   plc_state_type state_q;
   plc_state_type state_d;

   logic [plc_pkg::NUM_ELEM-1:0] lut_out;
   logic [plc_pkg::NUM_GROUP-1:0] group_tick;
   logic elem_hit;
   logic [4:0] elem_idx;

   // per-group clock: bus clock ticks every cycle, others on rising edge
   for (genvar g = 0; g < plc_pkg::NUM_GROUP; g++) begin : g_grp
      logic [2:0] sel;
      assign sel = state_q.clk_sel[g*plc_pkg::CLK_SEL_STRIDE +: 3];
      always_comb begin
         if (sel == plc_pkg::CLK_SYS_BUS) begin
            group_tick[g] = 1'b1;
         end else begin
            group_tick[g] = clk_src[sel] & ~state_q.src_prev[sel];
         end
      end
   end

   // logic elements
   for (genvar e = 0; e < plc_pkg::NUM_ELEM; e++) begin : g_elem
      localparam int GBASE = (e / plc_pkg::GROUP_SIZE) * plc_pkg::GROUP_SIZE;
      localparam int RING = (e + plc_pkg::NUM_ELEM - 1) % plc_pkg::NUM_ELEM;
      localparam bit FIRST = (e % plc_pkg::GROUP_SIZE) == 0;
      localparam bit HAS_GPIO = e < plc_pkg::GPIO_ELEMS;
      plc_pkg::plc_elem_cfg_type cfg;
      logic even_fb;
      logic odd_fb;
      logic in_a;
      logic in_b;
      assign cfg = state_q.elem[e];
      always_comb begin
         if (FIRST && cfg.even_feedback_select == 2'h0) begin
            even_fb = elem_out[RING];
         end else begin
            even_fb = elem_out[5'(GBASE) + {2'h0, cfg.even_feedback_select, 1'b0}];
         end
         odd_fb = elem_out[5'(GBASE) + {2'h0, cfg.odd_feedback_select, 1'b1}];
         in_a = cfg.first_input_select ? even_fb : state_q.sw_in[e];
         if (HAS_GPIO && cfg.second_input_select) begin
            in_b = gpio_in[e % plc_pkg::GPIO_ELEMS];
         end else begin
            in_b = odd_fb;
         end
      end
      assign lut_out[e] = cfg.lookup_function[{in_a, in_b}];
      assign elem_out[e] = cfg.register_bypass ? lut_out[e] : state_q.ff[e];
   end

   // interrupt lines follow the selected element while enabled
   assign irq_line[0] = state_q.irq_sel[plc_pkg::LINE0_EN_BIT]
      & elem_out[{1'b0, state_q.irq_sel[plc_pkg::LINE0_SRC_LSB +: 4]}];
   assign irq_line[1] = state_q.irq_sel[plc_pkg::LINE1_EN_BIT]
      & elem_out[{1'b0, state_q.irq_sel[plc_pkg::LINE1_SRC_LSB +: 4]}];
   assign irq = |(state_q.sts & state_q.mask);
   assign rdata = state_q.rdata;

   assign elem_hit = bus_req.addr >= plc_pkg::ELEM_BASE_ADDR
      && bus_req.addr <= plc_pkg::ELEM_LAST_ADDR
      && bus_req.addr[1:0] == 2'h0;
   assign elem_idx = bus_req.addr[6:2];

   always_comb begin
      state_d = state_q;
      state_d.src_prev = clk_src;
      state_d.rdata = 32'h0000_0000;
      // registered outputs clock on their group's tick
      for (int e = 0; e < plc_pkg::NUM_ELEM; e++) begin
         if (group_tick[e / plc_pkg::GROUP_SIZE]) begin
            state_d.ff[e] = lut_out[e];
         end
      end
      if (bus_req.wr) begin
         if (elem_hit) begin
            state_d.elem[elem_idx] = bus_req.wdata[15:0] & plc_pkg::ELEM_WMASK;
         end
         case (bus_req.addr)
            plc_pkg::CLK_SEL_ADDR: begin
               state_d.clk_sel = bus_req.wdata[15:0] & plc_pkg::CLK_SEL_WMASK;
            end
            plc_pkg::IRQ_SEL_ADDR: begin
               state_d.irq_sel = bus_req.wdata[15:0] & plc_pkg::IRQ_SEL_WMASK;
            end
            plc_pkg::SW_IN_ADDR: begin
               state_d.sw_in = bus_req.wdata;
            end
            plc_pkg::IRQ_STS_ADDR: begin
               state_d.sts = state_q.sts & ~bus_req.wdata[plc_pkg::NUM_LINE-1:0];
            end
            plc_pkg::IRQ_MASK_ADDR: begin
               state_d.mask = bus_req.wdata[plc_pkg::NUM_LINE-1:0];
            end
            default: begin
            end
         endcase
      end
      // set wins over a same-cycle clear
      state_d.sts = state_d.sts | irq_line;
      if (bus_req.rd) begin
         if (elem_hit) begin
            state_d.rdata = {16'h0000, state_q.elem[elem_idx]};
         end
         case (bus_req.addr)
            plc_pkg::CLK_SEL_ADDR: begin
               state_d.rdata = {16'h0000, state_q.clk_sel};
            end
            plc_pkg::IRQ_SEL_ADDR: begin
               state_d.rdata = {16'h0000, state_q.irq_sel};
            end
            plc_pkg::SW_IN_ADDR: begin
               state_d.rdata = state_q.sw_in;
            end
            plc_pkg::IRQ_STS_ADDR: begin
               state_d.rdata = {30'h0, state_q.sts};
            end
            plc_pkg::IRQ_MASK_ADDR: begin
               state_d.rdata = {30'h0, state_q.mask};
            end
            plc_pkg::ELEM_OUT_ADDR: begin
               state_d.rdata = elem_out;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

endmodule

// ---- rtl/plc_pkg.sv ----
// package for the programmable logic array configuration block
// assumes a 32-bit register port with byte addresses and one system clock
package plc_pkg;
   localparam int NUM_ELEM = 32;
   localparam int GROUP_SIZE = 8;
   localparam int NUM_GROUP = 4;
   localparam int NUM_CLK_SRC = 8;
   localparam int NUM_LINE = 2;
   localparam int GPIO_ELEMS = 16;
   localparam int IRQ_SRC_WIDTH = 4;

   // byte addresses
   localparam logic [31:0] ELEM_BASE_ADDR = 32'h4000_5800;
   localparam logic [31:0] ELEM_LAST_ADDR = 32'h4000_587c;
   localparam logic [31:0] ELEM_STEP = 32'h0000_0004;
   localparam logic [31:0] CLK_SEL_ADDR = 32'h4000_5880;
   localparam logic [31:0] IRQ_SEL_ADDR = 32'h4000_5884;
   localparam logic [31:0] SW_IN_ADDR = 32'h4000_58b0;
   localparam logic [31:0] IRQ_STS_ADDR = 32'h4000_58b4;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_58b8;
   localparam logic [31:0] ELEM_OUT_ADDR = 32'h4000_58bc;

   // writable bits; the rest read as zero
   localparam logic [15:0] ELEM_WMASK = 16'h07ff;
   localparam logic [15:0] CLK_SEL_WMASK = 16'h7777;
   localparam logic [15:0] IRQ_SEL_WMASK = 16'h1f1f;

   localparam logic [15:0] CFG_RESET = 16'h0000;

   // field positions of the interrupt select register, and the clock select stride
   localparam int LINE0_SRC_LSB = 0;
   localparam int LINE0_EN_BIT = 4;
   localparam int LINE1_SRC_LSB = 8;
   localparam int LINE1_EN_BIT = 12;
   localparam int CLK_SEL_STRIDE = 4;

   // group clock selector codes
   localparam logic [2:0] CLK_PIN_A = 3'h0;
   localparam logic [2:0] CLK_PIN_B = 3'h1;
   localparam logic [2:0] CLK_PIN_C = 3'h2;
   localparam logic [2:0] CLK_SYS_BUS = 3'h3;
   localparam logic [2:0] CLK_HIGH_SPEED_OSC = 3'h4;
   localparam logic [2:0] CLK_TIMER0 = 3'h5;
   localparam logic [2:0] CLK_TIMER2 = 3'h6;
   localparam logic [2:0] CLK_LOW_SPEED_OSC = 3'h7;

   typedef struct packed {
      logic [4:0] reserved;
      logic [1:0] even_feedback_select;
      logic [1:0] odd_feedback_select;
      logic first_input_select;
      logic second_input_select;
      logic [3:0] lookup_function;
      logic register_bypass;
   } plc_elem_cfg_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } plc_bus_req_type;
endpackage

// ---- verification/plc_array_cfg_test.sv ----
// self-checking bench for plc_array_cfg
// assumes the pin model and the port checker
module plc_array_cfg_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   plc_pkg::plc_bus_req_type bus_req = '0;
   logic [15:0] pins = 16'h0;
   logic [15:0] gpio_in;
   logic [7:0] clk_src;
   logic [31:0] rdata, elem_out;
   logic [31:0] seed = 32'h5;
   logic [1:0] irq_line;
   logic irq;
   int fails = 0;
   int compares = 0;
   plc_pins u_pins (.clk_sys(clk_sys), .pin_level(pins), .gpio_in(gpio_in), .clk_src(clk_src));
   plc_array_cfg dut (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
      .gpio_in(gpio_in), .clk_src(clk_src), .elem_out(elem_out), .irq_line(irq_line), .irq(irq));
   initial forever #10 clk_sys = ~clk_sys;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic lut(logic [3:0] f, logic a, logic b);
      return f[{a, b}];
   endfunction
   function automatic logic [31:0] ea(int n);
      return plc_pkg::ELEM_BASE_ADDR + 32'(4 * n);
   endfunction
   task automatic check(string nm, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic acc(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{a, d, w, !w};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [31:0] a, logic [31:0] e);
      acc(1'b0, a, 32'h0);
      check("rdata", rdata, e);
   endtask
   task automatic stop_test();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      logic [31:0] d;
      int c, v, k;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(plc_pkg::CLK_SEL_ADDR, 32'h0);
      rd(plc_pkg::IRQ_SEL_ADDR, 32'h0);
      rd(ea(5), 32'h0);
      acc(1, plc_pkg::CLK_SEL_ADDR, 32'hffff_ffff);
      rd(plc_pkg::CLK_SEL_ADDR, 32'h7777);
      rd(32'h4000_5888, 32'h0);
      for (int n = 0; n < 32; n++) begin
         d = rnd() & 32'hffff_fffe;
         acc(1, ea(n), d);
         rd(ea(n), d & 32'h7fe);
      end
      d = rnd();
      d = {27'h0, d[3:0], 1'b1} | 32'h20;
      acc(1, ea(0), d);
      for (k = 0; k < 4; k++) begin
         @(posedge clk_sys) pins <= {15'h0, k[0]};
         acc(1, plc_pkg::SW_IN_ADDR, {31'h0, k[1]});
         check("lookup", elem_out[0], lut(d[4:1], k[1], k[0]));
      end
      rd(plc_pkg::SW_IN_ADDR, 32'h1);
      // upper elements ignore the gpio select while pin 0 is high
      acc(1, ea(17), 32'h1);
      acc(1, ea(16), 32'h35);
      check("odd only", elem_out[16], 0);
      acc(0, plc_pkg::ELEM_OUT_ADDR, 32'h0);
      check("outputs", rdata[16], 0);
      for (c = 0; c < 4; c++) begin
         for (v = 0; v < 2; v++) begin
            d = v ? 32'h1f : 32'h1;
            acc(1, ea(8 + 2 * c), d);
            acc(1, ea(1 + 2 * c), d);
            acc(1, ea(9), 32'h59 | 32'(c << 9));
            acc(1, ea(2), 32'h15 | 32'(c << 7));
            check("even feedback", elem_out[9], v);
            check("odd feedback", elem_out[2], v);
         end
      end
      acc(1, ea(8), 32'h59);
      check("ring", elem_out[8], 1);
      acc(1, plc_pkg::CLK_SEL_ADDR, 32'h7773);
      acc(1, ea(0), 32'h1e);
      @(posedge clk_sys);
      #1;
      check("bus clocked", elem_out[0], 1);
      acc(1, plc_pkg::CLK_SEL_ADDR, 32'h7777);
      acc(1, ea(0), 32'h0);
      for (k = 0; k < 300 && elem_out[0] !== 1'b0; k++) begin
         @(posedge clk_sys);
         #1;
      end
      check("slow clock", k < 300, 1);
      if (k == 300) stop_test();
      acc(1, plc_pkg::IRQ_SEL_ADDR, 32'h1219);
      check("lines", irq_line, 2'h3);
      acc(1, plc_pkg::IRQ_MASK_ADDR, 32'h0);
      check("masked", irq, 0);
      acc(1, plc_pkg::IRQ_MASK_ADDR, 32'h3);
      check("irq", irq, 1);
      rd(plc_pkg::IRQ_MASK_ADDR, 32'h3);
      acc(1, ea(14), 32'h1);
      acc(1, ea(7), 32'h1);
      check("ring low", elem_out[8], 0);
      rd(plc_pkg::IRQ_STS_ADDR, 32'h3);
      acc(1, plc_pkg::IRQ_STS_ADDR, 32'h3);
      check("cleared", {irq_line, irq}, 0);
      stop_test();
   end
endmodule

// ---- verification/plc_pins.sv ----
// pin and clock source model beside the logic array
// assumes pin levels chosen by the bench
module plc_pins (
   input wire logic clk_sys,
   input wire logic [15:0] pin_level,
   output logic [15:0] gpio_in,
   output logic [7:0] clk_src
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q = 8'h0;
   always_ff @(posedge clk_sys) cnt_q <= cnt_q + 8'h1;
   assign gpio_in = pin_level;
   // sources of several rates
   assign clk_src = {cnt_q[7:4], 1'b0, cnt_q[2:0]};
endmodule

// ---- verification/plc_properties.sv ----
// port assertions for plc_array_cfg
// assumes config changes only through bus writes
module plc_properties (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire plc_pkg::plc_bus_req_type bus_req,
   input wire logic [31:0] rdata,
   input wire logic [31:0] elem_out,
   input wire logic [1:0] irq_line,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] clk_q, sel_q;
   logic mask_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clk_q <= 16'h0;
         sel_q <= 16'h0;
         mask_q <= 1'b0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == 32'h4000_5880) clk_q <= bus_req.wdata[15:0];
         if (bus_req.addr == 32'h4000_5884) sel_q <= bus_req.wdata[15:0];
         if (bus_req.addr == 32'h4000_58b8) mask_q <= bus_req.wdata[0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_rd(logic [31:0] a); bus_req.rd && bus_req.addr == a; endsequence
   property p_idle; !bus_req.rd |=> rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_res; s_rd(32'h4000_5800) |=> rdata[31:11] == 21'h0; endproperty
   a_res: assert property (p_res) else $error("reserved bits set");
   property p_clk; s_rd(32'h4000_5880) |=> rdata == {16'h0, clk_q & 16'h7777}; endproperty
   a_clk: assert property (p_clk) else $error("clock select readback");
   property p_sel; s_rd(32'h4000_5884) |=> rdata == {16'h0, sel_q & 16'h1f1f}; endproperty
   a_sel: assert property (p_sel) else $error("line select readback");
   property p_line0; irq_line[0] == (sel_q[4] && elem_out[sel_q[3:0]]); endproperty
   a_line0: assert property (p_line0) else $error("line 0 level");
   property p_line1; irq_line[1] == (sel_q[12] && elem_out[sel_q[11:8]]); endproperty
   a_line1: assert property (p_line1) else $error("line 1 level");
   property p_irq; irq_line[0] && mask_q && !bus_req.wr |=> irq; endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");
   property p_rst; $rose(rst_b) |-> !irq && irq_line == 2'h0; endproperty
   a_rst: assert property (p_rst) else $error("lines active after reset");
endmodule
bind plc_array_cfg plc_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b),
   .bus_req(bus_req), .rdata(rdata), .elem_out(elem_out), .irq_line(irq_line), .irq(irq));
